// *** verilog/tore_defines.svh ***
// Purpose: Shared constants of the tape object record encoder
// Assumes: 10 MHz system clock
// Notes: Character codes, run lengths and tone timing
`ifndef TORE_DEFINES_SVH
`define TORE_DEFINES_SVH

// Record and file characters
`define TORE_SEMI 8'h3B
`define TORE_CR 8'h0D
`define TORE_EOF 8'h1A
`define TORE_FINAL_ID 8'h00
`define TORE_PRINT_LO 8'h20
`define TORE_PRINT_HI 8'h7F

// Block framing characters and sizes
`define TORE_SYN 8'h16
`define TORE_ID_ASCII 8'h23
`define TORE_ID_BIN 8'h25
`define TORE_REC_MAX 5'h18
`define TORE_LINE_MAX 7'h4F
`define TORE_FIELD_LAST 7'h4E
`define TORE_SYN_FIRST 10'h200
`define TORE_SYN_SECOND_MIN 10'h06A
`define TORE_IRG_RESET 8'h50

// Tone timing: half cycle of the 2400 Hz tone
`define TORE_CLK_PERIOD_NS 32'h0000_0064
`define TORE_HALF_2400_NS 32'h0003_2DCD
`define TORE_HALF_CYCLES (`TORE_HALF_2400_NS / `TORE_CLK_PERIOD_NS)

`endif

// *** verilog/tore_pkg.sv ***
// Purpose: Types of the tape object record encoder
// Assumes: Constants come from tore_defines.svh
// Notes: State codes follow Gray order along the usual path
package tore_pkg;

  typedef enum logic [3:0] {
    FM_IDLE = 4'h0,
    FM_FILL = 4'h1,
    FM_SEMI = 4'h3,
    FM_COUNT = 4'h2,
    FM_ADDRH = 4'h6,
    FM_ADDRL = 4'h7,
    FM_DATA = 4'h5,
    FM_CKH = 4'h4,
    FM_CKL = 4'hC,
    FM_CR = 4'hD,
    FM_EOF = 4'hF,
    FM_TEXT = 4'hE,
    FM_DONE = 4'hA
  } tore_fmt_e;

  typedef enum logic [2:0] {
    FR_IDLE = 3'h0,
    FR_SYNC = 3'h1,
    FR_ID = 3'h3,
    FR_BLK = 3'h2,
    FR_DATA = 3'h6,
    FR_CKH = 3'h7,
    FR_CKL = 3'h5
  } tore_frm_e;

endpackage

// *** verilog/tore_encoder.sv ***
// Purpose: Record formatter, block framer and tone modulator for tape
// Assumes: Host handshake on sys_clk; one file at a time
// Notes: Byte stream is recorded as 2400/1200 Hz half-cycle patterns
//
// Functional notes
// - Object data is cut into records, each with start address, max 24 bytes.
// - Data records carry a byte count between 1 and 24.
// - Record order: semicolon, count, address, data, checksum, CR, 1A.
// - Record checksum sums the count, address and data bytes only.
// - Each record ends with carriage return 0D; the code sends 1A after it.
// - A file has at least one data record plus a unique final record.
// - Final record: semicolon, 00, record count, checksum, CR, 1A.
// - On tape hex fields are packed bytes; markers stay single bytes.
// - Packed byte holds one digit in bits 0-3, the other in 4-7.
// - Bit: positive 2400 Hz half, then three halves of 2400 or 1200 Hz.
// - Bit timing comes from a configurable tape bit rate constant.
// - Block: type byte, block number, 79 data bytes, two checksum bytes.
// - Every block is preceded by a run of 16 hex idle characters.
// - The first block is preceded by exactly 512 idle characters.
// - Between blocks twice the interblock sync setting idle characters.
// - Second block gets the larger of 106 and the setting's count.
// - Type byte is # for ASCII data, % for binary data.
// - Block number starts at 00, steps by one, wraps after FF.
// - Data field is laid out as first, middle or last block.
// - Text lines hold printable 20-7F characters, max 79, ended by CR.
// - Block checksum is the 16-bit sum of the 81 block bytes.
// - Unused data field bytes of the last block are zero filled.
`timescale 1ns/1ps
`include "tore_defines.svh"

module tore_encoder
  import tore_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic fileStart,
  input wire logic fileBinary,
  input wire logic [15:0] startAddr,
  input wire logic [7:0] inByte,
  input wire logic inValid,
  input wire logic inLast,
  input wire logic [7:0] interblockSyncSetting,
  input wire logic [15:0] tapeBitRateConstant,
  output logic inReady,
  output logic tapeOut,
  output logic busy
);

  tore_fmt_e fmState;
  tore_frm_e frState;
  logic [7:0] recBuf [0:23];
  logic [4:0] recLen;
  logic [4:0] dataIdx;
  logic [15:0] curAddr;
  logic [15:0] recNum;
  logic [15:0] recSum;
  logic [15:0] addrField;
  logic lastSeen;
  logic finalRec;
  logic binMode;
  logic justBroke;
  logic [6:0] lineLen;
  logic [7:0] fmtByte;
  logic fmtValid;
  logic [7:0] emitByte;
  logic fmEmit;
  logic fmDone;
  logic inTake;
  logic printable;
  logic [9:0] syncLeft;
  logic [9:0] syncTwice;
  logic [9:0] syncSecond;
  logic [9:0] syncRun;
  logic [7:0] blkNum;
  logic [6:0] fieldIdx;
  logic [15:0] blkSum;
  logic secondNext;
  logic canSend;
  logic sendNow;
  logic [7:0] txByte;
  logic fmtTake;
  logic startOk;
  logic [7:0] shReg;
  logic [2:0] bitCnt;
  logic [1:0] segIdx;
  logic [16:0] segTimer;
  logic [16:0] segLen;
  logic [15:0] halfLen;
  logic segEnd;
  logic serBusy;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  assign inTake = inValid && inReady;
  assign printable = (inByte >= `TORE_PRINT_LO) && (inByte <= `TORE_PRINT_HI);
  assign fmDone = (fmState == FM_DONE);
  assign addrField = finalRec ? recNum + 16'h0001 : curAddr;
  assign startOk = (fmState == FM_IDLE) && (frState == FR_IDLE) && !serBusy;

  // Formatter output byte for the current state
  always_comb begin
    emitByte = 8'h00;
    fmEmit = 1'b0;
    case (fmState)
      FM_SEMI: begin
        emitByte = `TORE_SEMI;
        fmEmit = !fmtValid;
      end
      FM_COUNT: begin
        emitByte = finalRec ? `TORE_FINAL_ID : {3'b000, recLen};
        fmEmit = !fmtValid;
      end
      FM_ADDRH: begin
        emitByte = addrField[15:8];
        fmEmit = !fmtValid;
      end
      FM_ADDRL: begin
        emitByte = addrField[7:0];
        fmEmit = !fmtValid;
      end
      FM_DATA: begin
        emitByte = recBuf[dataIdx];
        fmEmit = !fmtValid;
      end
      FM_CKH: begin
        emitByte = recSum[15:8];
        fmEmit = !fmtValid;
      end
      FM_CKL: begin
        emitByte = recSum[7:0];
        fmEmit = !fmtValid;
      end
      FM_CR: begin
        emitByte = `TORE_CR;
        fmEmit = !fmtValid;
      end
      FM_EOF: begin
        emitByte = `TORE_EOF;
        fmEmit = !fmtValid;
      end
      FM_TEXT: begin
        if (!fmtValid && lineLen == `TORE_LINE_MAX) begin
          emitByte = `TORE_CR;
          fmEmit = 1'b1;
        end else if (inTake && inByte == `TORE_CR) begin
          emitByte = inByte;
          fmEmit = !justBroke;
        end else if (inTake && printable) begin
          emitByte = inByte;
          fmEmit = 1'b1;
        end
      end
      default: begin
        emitByte = 8'h00;
        fmEmit = 1'b0;
      end
    endcase
  end

  // Record and text formatter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fmState <= FM_IDLE;
      recLen <= 5'h00;
      dataIdx <= 5'h00;
      curAddr <= 16'h0000;
      recNum <= 16'h0000;
      recSum <= 16'h0000;
      lastSeen <= 1'b0;
      finalRec <= 1'b0;
      binMode <= 1'b0;
      justBroke <= 1'b0;
      lineLen <= 7'h00;
    end else begin
      case (fmState)
        FM_IDLE: if (startOk && fileStart) begin
          binMode <= fileBinary;
          curAddr <= startAddr;
          recNum <= 16'h0000;
          recLen <= 5'h00;
          finalRec <= 1'b0;
          lastSeen <= 1'b0;
          lineLen <= 7'h00;
          justBroke <= 1'b0;
          fmState <= fileBinary ? FM_FILL : FM_TEXT;
        end
        FM_FILL: if (inTake) begin
          recBuf[recLen] <= inByte;
          recLen <= recLen + 5'h01;
          if (inLast || recLen == `TORE_REC_MAX - 5'h01) begin
            lastSeen <= inLast;
            fmState <= FM_SEMI;
          end
        end
        FM_SEMI: if (fmEmit) begin
          fmState <= FM_COUNT;
        end
        FM_COUNT: if (fmEmit) begin
          recSum <= {8'h00, emitByte};
          fmState <= FM_ADDRH;
        end
        FM_ADDRH: if (fmEmit) begin
          recSum <= recSum + {8'h00, emitByte};
          fmState <= FM_ADDRL;
        end
        FM_ADDRL: if (fmEmit) begin
          recSum <= recSum + {8'h00, emitByte};
          dataIdx <= 5'h00;
          fmState <= finalRec ? FM_CKH : FM_DATA;
        end
        FM_DATA: if (fmEmit) begin
          recSum <= recSum + {8'h00, emitByte};
          dataIdx <= dataIdx + 5'h01;
          if (dataIdx == recLen - 5'h01) begin
            fmState <= FM_CKH;
          end
        end
        FM_CKH: if (fmEmit) begin
          fmState <= FM_CKL;
        end
        FM_CKL: if (fmEmit) begin
          fmState <= FM_CR;
        end
        FM_CR: if (fmEmit) begin
          fmState <= FM_EOF;
        end
        FM_EOF: if (fmEmit) begin
          if (finalRec) begin
            fmState <= FM_DONE;
          end else begin
            recNum <= recNum + 16'h0001;
            curAddr <= curAddr + {11'h000, recLen};
            recLen <= 5'h00;
            finalRec <= lastSeen;
            fmState <= lastSeen ? FM_SEMI : FM_FILL;
          end
        end
        FM_TEXT: begin
          if (!fmtValid && lineLen == `TORE_LINE_MAX) begin
            lineLen <= 7'h00;
            justBroke <= 1'b1;
          end else if (inTake) begin
            if (inByte == `TORE_CR) begin
              lineLen <= 7'h00;
              justBroke <= 1'b0;
            end else if (printable) begin
              lineLen <= lineLen + 7'h01;
              justBroke <= 1'b0;
            end
            if (inLast) begin
              finalRec <= 1'b1;
              fmState <= FM_EOF;
            end
          end
        end
        FM_DONE: if (frState == FR_IDLE) begin
          fmState <= FM_IDLE;
        end
        default: fmState <= FM_IDLE;
      endcase
    end
  end

  // One-byte hand-off from formatter to framer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fmtValid <= 1'b0;
      fmtByte <= 8'h00;
    end else if (fmEmit) begin
      fmtValid <= 1'b1;
      fmtByte <= emitByte;
    end else if (fmtTake) begin
      fmtValid <= 1'b0;
    end
  end

  // Host ready only while the formatter can take a byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      inReady <= 1'b0;
    end else begin
      inReady <= !inTake && !fmtValid && ((fmState == FM_FILL) ||
        (fmState == FM_TEXT && lineLen != `TORE_LINE_MAX));
    end
  end

  assign syncTwice = {1'b0, interblockSyncSetting, 1'b0};
  assign syncSecond = (syncTwice > `TORE_SYN_SECOND_MIN) ? syncTwice :
    `TORE_SYN_SECOND_MIN;

  always_comb begin
    canSend = 1'b0;
    txByte = 8'h00;
    case (frState)
      FR_SYNC: begin
        canSend = (syncLeft != 10'h000);
        txByte = `TORE_SYN;
      end
      FR_ID: begin
        canSend = 1'b1;
        txByte = binMode ? `TORE_ID_BIN : `TORE_ID_ASCII;
      end
      FR_BLK: begin
        canSend = 1'b1;
        txByte = blkNum;
      end
      FR_DATA: begin
        canSend = fmtValid || fmDone;
        txByte = fmtValid ? fmtByte : 8'h00;
      end
      FR_CKH: begin
        canSend = 1'b1;
        txByte = blkSum[15:8];
      end
      FR_CKL: begin
        canSend = 1'b1;
        txByte = blkSum[7:0];
      end
      default: begin
        canSend = 1'b0;
        txByte = 8'h00;
      end
    endcase
  end

  assign sendNow = canSend && !serBusy;
  assign fmtTake = sendNow && (frState == FR_DATA) && fmtValid;

  // Block framer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frState <= FR_IDLE;
      syncLeft <= 10'h000;
      blkNum <= 8'h00;
      fieldIdx <= 7'h00;
      blkSum <= 16'h0000;
      secondNext <= 1'b0;
    end else begin
      case (frState)
        FR_IDLE: if (startOk && fileStart) begin
          syncLeft <= `TORE_SYN_FIRST;
          blkNum <= 8'h00;
          secondNext <= 1'b1;
          frState <= FR_SYNC;
        end
        FR_SYNC: begin
          if (syncLeft == 10'h000) begin
            frState <= FR_ID;
          end else if (sendNow) begin
            syncLeft <= syncLeft - 10'h001;
          end
        end
        FR_ID: if (sendNow) begin
          blkSum <= {8'h00, txByte};
          frState <= FR_BLK;
        end
        FR_BLK: if (sendNow) begin
          blkSum <= blkSum + {8'h00, txByte};
          fieldIdx <= 7'h00;
          frState <= FR_DATA;
        end
        FR_DATA: if (sendNow) begin
          blkSum <= blkSum + {8'h00, txByte};
          fieldIdx <= fieldIdx + 7'h01;
          if (fieldIdx == `TORE_FIELD_LAST) begin
            frState <= FR_CKH;
          end
        end
        FR_CKH: if (sendNow) begin
          frState <= FR_CKL;
        end
        FR_CKL: if (sendNow) begin
          blkNum <= blkNum + 8'h01;
          secondNext <= 1'b0;
          if (fmDone && !fmtValid) begin
            frState <= FR_IDLE;
          end else begin
            syncLeft <= secondNext ? syncSecond : syncTwice;
            frState <= FR_SYNC;
          end
        end
        default: frState <= FR_IDLE;
      endcase
    end
  end

  // Tone modulator; zero constant falls back to the nominal rate
  assign halfLen = (tapeBitRateConstant == 16'h0000) ?
    16'(`TORE_HALF_CYCLES) : tapeBitRateConstant;
  assign segLen = (segIdx == 2'h0 || shReg[0]) ? {1'b0, halfLen} :
    {halfLen, 1'b0};
  assign segEnd = (segTimer == segLen - 17'h0_0001);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shReg <= 8'h00;
      bitCnt <= 3'h0;
      segIdx <= 2'h0;
      segTimer <= 17'h0_0000;
      serBusy <= 1'b0;
    end else if (!serBusy) begin
      if (sendNow) begin
        shReg <= txByte;
        bitCnt <= 3'h0;
        segIdx <= 2'h0;
        segTimer <= 17'h0_0000;
        serBusy <= 1'b1;
      end
    end else if (segEnd) begin
      segTimer <= 17'h0_0000;
      if (segIdx == 2'h3) begin
        segIdx <= 2'h0;
        shReg <= {1'b0, shReg[7:1]};
        bitCnt <= bitCnt + 3'h1;
        if (bitCnt == 3'h7) begin
          serBusy <= 1'b0;
        end
      end else begin
        segIdx <= segIdx + 2'h1;
      end
    end else begin
      segTimer <= segTimer + 17'h0_0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tapeOut <= 1'b0;
      busy <= 1'b0;
    end else begin
      tapeOut <= serBusy && !segIdx[0];
      busy <= serBusy || (frState != FR_IDLE) || (fmState != FM_IDLE);
    end
  end

  // Idle characters sent in the current run
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncRun <= 10'h000;
    end else if (frState != FR_SYNC) begin
      syncRun <= 10'h000;
    end else if (sendNow) begin
      syncRun <= syncRun + 10'h001;
    end
  end

  a_count_range: assert property (
    (fmState == FM_COUNT && fmEmit && !finalRec) |->
      (emitByte >= 8'h01) && (emitByte <= 8'h18))
    else $error("record byte count out of range");
  a_rec_len_max: assert property (
    recLen <= `TORE_REC_MAX)
    else $error("record holds too many bytes");
  a_start_semi: assert property (
    $fell(fmState == FM_SEMI) |-> fmtByte == `TORE_SEMI && fmtValid)
    else $error("record did not open with semicolon");
  a_cr_then_eof: assert property (
    $fell(fmState == FM_CR) |-> fmtByte == `TORE_CR && fmState == FM_EOF)
    else $error("carriage return not followed by end marker");
  a_final_id: assert property (
    (fmState == FM_COUNT && fmEmit && finalRec) |-> emitByte == 8'h00)
    else $error("final record identifier wrong");
  a_line_len: assert property (
    lineLen <= `TORE_LINE_MAX)
    else $error("text line too long");
  a_first_sync: assert property (
    (frState == FR_SYNC && syncLeft == 10'h000 && secondNext) |->
      syncRun == 10'h200)
    else $error("first block idle run not 512");
  a_gap_sync: assert property (
    (frState == FR_SYNC && syncLeft == 10'h000 && !secondNext &&
      blkNum != 8'h01) |-> syncRun == syncTwice)
    else $error("interblock idle run wrong");
  a_id_byte: assert property (
    (frState == FR_ID && sendNow) |->
      txByte == (binMode ? 8'h25 : 8'h23))
    else $error("data type byte wrong");
  a_blk_step: assert property (
    (frState == FR_CKL && sendNow) |=> blkNum == $past(blkNum) + 8'h01)
    else $error("block number did not step");
  a_zero_fill: assert property (
    (frState == FR_DATA && sendNow && !fmtValid) |=>
      shReg == 8'h00 && serBusy)
    else $error("last block not zero filled");
  a_lead_half: assert property (
    (serBusy && segIdx == 2'h0 && segEnd) |=>
      segIdx == 2'h1 && $past(segTimer) == {1'b0, halfLen} - 17'h0_0001)
    else $error("leading half cycle length wrong");
  a_lsb_first: assert property (
    (serBusy && segIdx == 2'h3 && segEnd && bitCnt != 3'h7) |=>
      shReg == {1'b0, $past(shReg[7:1])} && segIdx == 2'h0)
    else $error("bits not shifted LSB first");

endmodule // tore_encoder

// *** bench/tore_tape_reader.sv ***
// Purpose: Tape reader model that turns the tone back into bytes
// Assumes: Tone sampled on sys_clk; half cycle length given in clocks
// Notes: Hunts for the idle pattern each time it is enabled, then frames every 8 bits
`timescale 1ns/1ps

module tore_tape_reader (
  input wire logic sys_clk,
  input wire logic enable,
  input wire logic tapeIn,
  input wire logic [15:0] halfClks,
  output logic [7:0] rxByte,
  output logic rxStrobe,
  output logic badTone
);
  logic prevIn = 1'b0;
  logic midBit = 1'b0;
  logic inSync = 1'b0;
  logic [7:0] shiftReg = 8'h00;
  logic [7:0] next_shift;
  logic bitVal;
  int highCnt = 0;
  int lowCnt = 0;
  int nBits = 0;

  initial begin
    rxByte = 8'h00;
    rxStrobe = 1'b0;
    badTone = 1'b0;
  end

  always @(posedge sys_clk) begin
    rxStrobe <= 1'b0;
    prevIn <= tapeIn;
    highCnt <= (tapeIn && !prevIn) ? 1 : highCnt + int'(tapeIn);
    lowCnt <= (tapeIn && !prevIn) ? 0 : lowCnt + int'(!tapeIn);
    if (!enable) begin
      midBit <= 1'b0;
      inSync <= 1'b0;
      shiftReg <= 8'h00;
      nBits <= 0;
    end else if (!tapeIn && prevIn && midBit) begin
      // Leading positive half of a bit is one 2400 Hz half
      if (highCnt != int'(halfClks)) badTone <= 1'b1;
    end else if (tapeIn && !prevIn && !midBit) begin
      midBit <= 1'b1;
    end else if (tapeIn && !prevIn) begin
      midBit <= 1'b0;
      bitVal = (lowCnt == int'(halfClks));
      if (!bitVal && lowCnt != 2 * int'(halfClks)) badTone <= 1'b1;
      next_shift = {bitVal, shiftReg[7:1]};
      shiftReg <= next_shift;
      if (!inSync) begin
        // Byte framing locks on the first idle character
        if (next_shift == 8'h16) inSync <= 1'b1;
        nBits <= 0;
      end else if (nBits == 7) begin
        rxByte <= next_shift;
        rxStrobe <= 1'b1;
        nBits <= 0;
      end else begin
        nBits <= nBits + 1;
      end
    end
  end
endmodule // tore_tape_reader

// *** bench/tb.sv ***
// Purpose: Self-checking bench of the tape object record encoder
// Assumes: Tape reader model decodes the tone into a byte queue
// Notes: First idle character is eaten by the reader's hunt
`timescale 1ns/1ps
`include "tore_defines.svh"

module tb;
  localparam logic [15:0] HALF = 16'h0001;
  localparam logic [7:0] GAP_SET = 8'h0A;
  logic sys_clk, rst_n, fileStart, fileBinary, inValid, inLast;
  logic inReady, tapeOut, busy, tookByte, rxStrobe, badTone;
  logic [15:0] startAddr;
  logic [7:0] inByte, rxByte;
  logic [8:0] hostQ[$];
  logic [7:0] rxQ[$];
  int n_fail = 0;
  int total_checks = 0;

  tore_encoder u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .fileStart(fileStart),
    .fileBinary(fileBinary), .startAddr(startAddr), .inByte(inByte),
    .inValid(inValid), .inLast(inLast),
    .interblockSyncSetting(GAP_SET), .tapeBitRateConstant(HALF),
    .inReady(inReady), .tapeOut(tapeOut), .busy(busy)
  );

  tore_tape_reader u_reader (
    .sys_clk(sys_clk), .enable(busy), .tapeIn(tapeOut), .halfClks(HALF),
    .rxByte(rxByte), .rxStrobe(rxStrobe), .badTone(badTone)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    tookByte <= inValid && inReady;
    if (rxStrobe) rxQ.push_back(rxByte);
  end

  // Host source: holds each byte until the encoder takes it
  always @(negedge sys_clk) begin
    if (!rst_n) inValid = 1'b0;
    else if (tookByte || !inValid) begin
      if (hostQ.size() > 0) begin
        {inLast, inByte} = hostQ.pop_front();
        inValid = 1'b1;
      end else inValid = 1'b0;
    end
  end

  task automatic start_file(input logic bin);
    @(negedge sys_clk);
    fileBinary = bin;
    fileStart = 1'b1;
    @(negedge sys_clk);
    fileStart = 1'b0;
  endtask

  task automatic test_text();
    int n;
    int k;
    rxQ.delete();
    start_file(1'b0);
    hostQ = {9'h048, 9'h001, 9'h069, 9'h10D};
    k = 0;
    while (rxQ.size() < 517 && k < 40000) begin
      @(negedge sys_clk);
      k++;
    end
    n = 0;
    while (n < rxQ.size() && rxQ[n] == 8'h16) n++;
    check(16'(n), 16'h01FF);
    check(rxQ[511], `TORE_ID_ASCII);
    check(rxQ[512], 8'h00);
    check(rxQ[513], 8'h48);
    check(rxQ[514], 8'h69);
    check(rxQ[515], `TORE_CR);
    check(rxQ[516], `TORE_EOF);
    // Reset in mid file must silence the tone at once
    rst_n = 1'b0;
    hostQ.delete();
    repeat (3) @(negedge sys_clk);
    check({inReady, tapeOut, busy}, 16'h0000);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(busy, 1'b0);
    $display("text test done, fails=%0d", n_fail);
  endtask

  task automatic test_object();
    logic [7:0] fld[$];
    logic [7:0] exp[$];
    logic [15:0] sum, addr, cks;
    logic [7:0] d, cnt;
    int i, j, k, b;
    rxQ.delete();
    startAddr = 16'h1FF0;
    start_file(1'b1);
    addr = 16'h1FF0;
    i = 0;
    for (j = 0; j < 5; j++) begin
      cnt = (j < 4) ? `TORE_REC_MAX : 8'h12;
      sum = {8'h00, cnt} + addr[15:8] + addr[7:0];
      fld = {fld, 8'h3B, cnt, addr[15:8], addr[7:0]};
      for (k = 0; k < int'(cnt); k++) begin
        d = 8'(i * 7 + 3);
        sum += d;
        fld.push_back(d);
        hostQ.push_back({i == 113, d});
        i++;
      end
      fld = {fld, sum[15:8], sum[7:0], `TORE_CR, `TORE_EOF};
      addr += cnt;
    end
    fld = {fld, 8'h3B, 8'h00, 8'h00, 8'h06, 8'h00, 8'h06, 8'h0D, 8'h1A};
    while (fld.size() < 237) fld.push_back(8'h00);
    // Third block gap is twice the setting, below the second block floor
    for (b = 0; b < 3; b++) begin
      repeat (b == 0 ? 511 : (b == 1 ? 106 : 2 * int'(GAP_SET)))
        exp.push_back(`TORE_SYN);
      cks = 16'h0025 + 16'(b);
      exp = {exp, `TORE_ID_BIN, 8'(b)};
      for (j = 0; j < 79; j++) begin
        exp.push_back(fld[79 * b + j]);
        cks += fld[79 * b + j];
      end
      exp = {exp, cks[15:8], cks[7:0]};
    end
    // A second start while busy must not disturb the file
    repeat (1000) @(negedge sys_clk);
    start_file(1'b0);
    k = 0;
    while (busy && k < 60000) begin
      @(negedge sys_clk);
      k++;
    end
    check(16'(rxQ.size()), 16'(exp.size()));
    for (i = 0; i < exp.size() && i < rxQ.size(); i++) begin
      check(rxQ[i], exp[i]);
    end
    for (i = 0; i < exp.size() && i < rxQ.size(); i++) begin
      check(rxQ[i], exp[i]);
    end
    check(badTone, 1'b0);
    $display("object test done, fails=%0d", n_fail);
  endtask

  initial begin
    repeat (90000) @(posedge sys_clk);
    n_fail++;
    $display("Timeout at %0t", $time);
    results();
  end

  initial begin
    rst_n = 1'b0;
    fileStart = 1'b0;
    fileBinary = 1'b0;
    startAddr = 16'h0000;
    inByte = 8'h00;
    inValid = 1'b0;
    inLast = 1'b0;
    tookByte = 1'b0;
    repeat (6) @(negedge sys_clk);
    check({inReady, tapeOut, busy}, 16'h0000);
    rst_n = 1'b1;
    test_text();
    test_object();
    results();
  end
endmodule // tb
